/* File: hdl/snt_regs.svh */
`ifndef SNT_REGS_SVH
`define SNT_REGS_SVH

// ----------------------------------------
// register indices (word addresses)
// ----------------------------------------
`define SNT_REG_CON1 3'h0
`define SNT_REG_CON2 3'h1
`define SNT_REG_CON3 3'h2
`define SNT_REG_STAT 3'h3
`define SNT_REG_DATL 3'h4
`define SNT_REG_DATH 3'h5
`define SNT_REG_SYNC 3'h6

// ----------------------------------------
// link_control_one fields
// ----------------------------------------
`define SNT_EN 15
`define SNT_SIDL 13
`define SNT_RCV 11
`define SNT_TXM 10
`define SNT_POL 9
`define SNT_HW_CHECKSUM_ENABLE 8
`define SNT_PPP 7
`define SNT_SPC 6
`define SNT_PS 4
`define SNT_CON1_WMASK 16'hafd7
`define SNT_CON1_RESET 16'h0000

// ----------------------------------------
// link_status fields
// ----------------------------------------
`define SNT_ST_PAUSE 7
`define SNT_ST_CHECKSUM_ERROR_FLAG 3
`define SNT_ST_FRAMING_ERROR_FLAG 2
`define SNT_ST_SYNCTX 0

// ----------------------------------------
// timing in ticks, and checksum constants
// ----------------------------------------
`define SNT_SYNC_TICKS 12'h038
`define SNT_NIB_BASE 12'h00c
`define SNT_NIB_MAX 5'h1b
`define SNT_NIB_MIN 5'h0c
`define SNT_PULSE_TICKS 12'h005
`define SNT_PAUSE_MIN 12'h00c
`define SNT_FRAME_CAP 12'h7ff
`define SNT_CRC_SEED 4'h5
`define SNT_CRC_POLY 4'hd
`define SNT_NIB_CRC 3'h7
`define SNT_PS_DIV 2'h3

`endif

/* File: hdl/snt_pkg.sv */
package snt_pkg;
	typedef logic [2:0] snt_addr_t;
	typedef logic [3:0] snt_nib_t;
	typedef enum logic [1:0]
	{
		TX_IDLE = 2'b00,
		TX_SYNC = 2'b01,
		TX_NIB = 2'b11,
		TX_PAUSE = 2'b10
	} snt_tx_state_t;
endpackage : snt_pkg

/* File: hdl/snt_tick_gen.sv */
`timescale 1ns/1ns
`include "snt_regs.svh"

module snt_tick_gen #(
	parameter int W = 16
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic divSel,
	input wire logic [W-1:0] period,
	output logic psEn,
	output logic tickEn
);
	import snt_pkg::*;

	logic [1:0] psCnt_ff;
	logic [W-1:0] tickCnt_ff;
	logic psHit;

	// ----------------------------------------
	// prescaler: divide by 4 or by 1
	// ----------------------------------------
	assign psHit = run && (!divSel || psCnt_ff == `SNT_PS_DIV);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			psCnt_ff <= 2'h0;
		else if (!run || psHit)
			psCnt_ff <= 2'h0;
		else
			psCnt_ff <= psCnt_ff + 2'h1;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			psEn <= 1'b0;
		else
			psEn <= psHit;
	end

	// ----------------------------------------
	// tick: period + 1 prescaled clocks
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tickCnt_ff <= '0;
			tickEn <= 1'b0;
		end
		else if (!run)
		begin
			tickCnt_ff <= '0;
			tickEn <= 1'b0;
		end
		else
		begin
			tickEn <= psHit && tickCnt_ff >= period;
			if (psHit)
				tickCnt_ff <= (tickCnt_ff >= period) ? '0 : tickCnt_ff + 1'b1;
		end
	end
endmodule : snt_tick_gen

/* File: hdl/snt_transceiver.sv */
// Behaviour
// - transmit tick lasts tick_period_value plus one prescaled clocks.
// - async pause stretches frame to frame_period_value ticks; pause >= 12; cap 2047.
// - receive_select bit 11 picks receiver; transmitter after reset.
// - transmit_trigger_mode bit 10: triggered single frames or continuous frames.
// - output_idle_polarity bit 9 set idles line low, clear idles high.
// - hw_checksum_enable bit 8 checks received or generates transmitted checksum.
// - pause_present bit 7 sends or expects a pause after the checksum nibble.
// - receive only, short_pwm_code_enable bit 6 gates external trigger control.
// - clock_divider_select bit 4 divides by four, else by one.
// - data_nibble_count codes 1 to 6 give data nibbles; 0 and 7 reserved.
// - stop_in_idle bit 13 halts the block while the system idles.
// - receiver starts frames only on sync intervals within the window; captures it.
// - each nibble interval is checked, stored, and frame end raises an event.
// - status bit 7 reads one during a pause period.
// - transmit nibble status: 7 checksum, 1-6 data, 0 otherwise.
// - each nibble is value plus 12 ticks, 12 to 27 ticks.
// - every frame opens with a 56 tick sync period.
// - receiver flags a framing error on nibbles below 12 or above 27 ticks.
// - sync_or_send_trigger starts one frame, stays set, clears at frame end.
`timescale 1ns/1ns
`include "snt_regs.svh"

module snt_transceiver (
	input wire logic core_clk,
	input wire logic rstn,
	input wire snt_pkg::snt_addr_t regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdData,
	input wire logic idleMode,
	input wire logic rxIn,
	output logic txOut,
	output logic txOe_n,
	output logic frameDone,
	output logic spcEnable
);
	import snt_pkg::*;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic snt_nib_t crcNib(input snt_nib_t c, input snt_nib_t d);
		snt_nib_t t;
		t = c;
		for (int i = 0; i < 4; i++)
			t = t[3] ? ({t[2:0], 1'b0} ^ `SNT_CRC_POLY) : {t[2:0], 1'b0};
		return t ^ d;
	endfunction : crcNib

	function automatic snt_nib_t nibSel(input logic [15:0] h, input logic [15:0] l,
		input logic [2:0] idx);
		logic [31:0] all;
		all = {h, l};
		return all[31 - 4 * idx -: 4];
	endfunction : nibSel

	function automatic logic [2:0] nibCount(input logic [2:0] code);
		if (code == 3'h0)
			return 3'h1;
		else if (code == 3'h7)
			return 3'h6;
		else
			return code;
	endfunction : nibCount

	// rounded ticks of an interval, with the sync period being 56 ticks
	function automatic logic [4:0] ticksOf(input logic [15:0] iv, input logic [15:0] sc);
		logic [23:0] a;
		logic [23:0] b;
		logic [4:0] n;
		a = 24'({8'h00, iv} * 24'h000070);
		n = 5'h0b;
		for (int k = 12; k <= 28; k++)
		begin
			b = 24'({8'h00, sc} * 24'(2 * k - 1));
			if (a >= b)
				n = n + 5'h01;
		end
		return n;
	endfunction : ticksOf

	// ----------------------------------------
	// registers and decode
	// ----------------------------------------
	logic [15:0] con1_ff;
	logic [15:0] con2_ff;
	logic [15:0] con3_ff;
	logic [15:0] datH_ff;
	logic [15:0] datL_ff;
	logic [15:0] syncCap_ff;
	logic syncTx_ff;
	logic checksum_error_flag_ff;
	logic framing_error_flag_ff;
	logic idle_ff;
	snt_tx_state_t txState_ff;
	logic [2:0] txNib_ff;
	logic [11:0] segCnt_ff;
	logic [11:0] segLen_ff;
	logic [11:0] frameCnt_ff;
	logic rxSynced_ff;
	logic rxPause_ff;
	logic rxPrev_ff;
	logic [2:0] rxNib_ff;
	logic [15:0] measCnt_ff;
	logic [3:0] rxCrc_ff;

	logic en, rx, transmit_trigger_mode, pol, hw_checksum_enable, pause_present, run;
	logic [2:0] data_nibble_count;
	logic psEn, tickEn;
	logic [3:0] calcCrc;
	logic [3:0] txCrc;
	logic lastTick, txFrameEnd, txGo;
	logic [11:0] frameLim, usedTicks, pauseLen;
	logic fallEdge, inWindow, rxNibEdge, rxBad, rxStore, rxDone, rxCrcBad;
	logic [4:0] rxTicks;
	logic [3:0] rxVal;
	logic [7:0] statLow;
	logic wrStat;

	assign en = con1_ff[`SNT_EN];
	assign rx = con1_ff[`SNT_RCV];
	assign transmit_trigger_mode = con1_ff[`SNT_TXM];
	assign pol = con1_ff[`SNT_POL];
	assign hw_checksum_enable = con1_ff[`SNT_HW_CHECKSUM_ENABLE];
	assign pause_present = con1_ff[`SNT_PPP];
	assign data_nibble_count = nibCount(con1_ff[2:0]);
	assign run = en && !(con1_ff[`SNT_SIDL] && idleMode);
	assign wrStat = regWr && regAddr == `SNT_REG_STAT;

	snt_tick_gen #(
		.W(16)
	) snt_tick_gen_i (
		.core_clk(core_clk),
		.rstn(rstn),
		.run(run),
		.divSel(con1_ff[`SNT_PS]),
		.period(con2_ff),
		.psEn(psEn),
		.tickEn(tickEn)
	);

	// ----------------------------------------
	// software-written registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			con1_ff <= `SNT_CON1_RESET;
			con2_ff <= 16'h0000;
			con3_ff <= 16'h0000;
		end
		else if (regWr)
		begin
			if (regAddr == `SNT_REG_CON1)
				con1_ff <= regWrData & `SNT_CON1_WMASK;
			if (regAddr == `SNT_REG_CON2)
				con2_ff <= regWrData;
			if (regAddr == `SNT_REG_CON3)
				con3_ff <= regWrData;
		end
	end

	// data registers: software owns them when sending, the receiver when receiving
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			datH_ff <= 16'h0000;
			datL_ff <= 16'h0000;
		end
		else if (rx)
		begin
			if (rxStore)
			begin
				if (rxNib_ff == `SNT_NIB_CRC)
					datL_ff[3:0] <= rxVal;
				else if (rxNib_ff < 3'h4)
					datH_ff[15 - 4 * rxNib_ff -: 4] <= rxVal;
				else
					datL_ff[31 - 4 * rxNib_ff -: 4] <= rxVal;
			end
		end
		else if (regWr)
		begin
			if (regAddr == `SNT_REG_DATH)
				datH_ff <= regWrData;
			if (regAddr == `SNT_REG_DATL)
				datL_ff <= hw_checksum_enable ? {regWrData[15:4], datL_ff[3:0]} : regWrData;
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	always_comb
	begin
		calcCrc = `SNT_CRC_SEED;
		for (int i = 1; i <= 6; i++)
			if (3'(i) <= data_nibble_count)
				calcCrc = crcNib(calcCrc, nibSel(datH_ff, datL_ff, 3'(i)));
		calcCrc = crcNib(calcCrc, 4'h0);
	end

	assign txCrc = hw_checksum_enable ? calcCrc : datL_ff[3:0];
	assign lastTick = segCnt_ff == segLen_ff - 12'h001;
	assign txFrameEnd = tickEn && lastTick && (txState_ff == TX_PAUSE
		|| (txState_ff == TX_NIB && txNib_ff == `SNT_NIB_CRC && !pause_present));
	assign txGo = transmit_trigger_mode ? syncTx_ff : 1'b1;
	assign frameLim = (con3_ff > 16'(`SNT_FRAME_CAP)) ? `SNT_FRAME_CAP : con3_ff[11:0];
	assign usedTicks = frameCnt_ff + 12'h001;
	// in continuous mode the pause fills the frame up to its programmed length, never under 12 ticks
	assign pauseLen = (!transmit_trigger_mode && frameLim > usedTicks + `SNT_PAUSE_MIN)
		? frameLim - usedTicks : `SNT_PAUSE_MIN;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			txState_ff <= TX_IDLE;
			txNib_ff <= 3'h0;
			segCnt_ff <= 12'h000;
			segLen_ff <= 12'h001;
			frameCnt_ff <= 12'h000;
		end
		else if (!en || rx)
		begin
			txState_ff <= TX_IDLE;
			txNib_ff <= 3'h0;
			segCnt_ff <= 12'h000;
		end
		else if (tickEn)
		begin
			segCnt_ff <= segCnt_ff + 12'h001;
			frameCnt_ff <= frameCnt_ff + 12'h001;
			unique case (txState_ff)
				TX_IDLE:
				begin
					segCnt_ff <= 12'h000;
					if (txGo)
					begin
						txState_ff <= TX_SYNC;
						segLen_ff <= `SNT_SYNC_TICKS;
						frameCnt_ff <= 12'h000;
					end
				end
				TX_SYNC:
					if (lastTick)
					begin
						txState_ff <= TX_NIB;
						txNib_ff <= 3'h0;
						segCnt_ff <= 12'h000;
						segLen_ff <= `SNT_NIB_BASE + {8'h00, datH_ff[15:12]};
					end
				TX_NIB:
					if (lastTick)
					begin
						segCnt_ff <= 12'h000;
						if (txNib_ff == `SNT_NIB_CRC && pause_present)
						begin
							txState_ff <= TX_PAUSE;
							segLen_ff <= pauseLen;
						end
						else if (txNib_ff == `SNT_NIB_CRC)
						begin
							txState_ff <= (transmit_trigger_mode || !run) ? TX_IDLE : TX_SYNC;
							segLen_ff <= `SNT_SYNC_TICKS;
							frameCnt_ff <= 12'h000;
							txNib_ff <= 3'h0;
						end
						else if (txNib_ff == data_nibble_count)
						begin
							txNib_ff <= `SNT_NIB_CRC;
							segLen_ff <= `SNT_NIB_BASE + {8'h00, txCrc};
						end
						else
						begin
							txNib_ff <= txNib_ff + 3'h1;
							segLen_ff <= `SNT_NIB_BASE
								+ {8'h00, nibSel(datH_ff, datL_ff, txNib_ff + 3'h1)};
						end
					end
				TX_PAUSE:
					if (lastTick)
					begin
						txState_ff <= transmit_trigger_mode ? TX_IDLE : TX_SYNC;
						segCnt_ff <= 12'h000;
						segLen_ff <= `SNT_SYNC_TICKS;
						frameCnt_ff <= 12'h000;
						txNib_ff <= 3'h0;
					end
			endcase
		end
	end

	// set by software wins over the clear at frame end
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			syncTx_ff <= 1'b0;
		else if (!en || rx || !transmit_trigger_mode)
			syncTx_ff <= 1'b0;
		else if (wrStat && regWrData[`SNT_ST_SYNCTX])
			syncTx_ff <= 1'b1;
		else if (txFrameEnd)
			syncTx_ff <= 1'b0;
	end

	// an edge away from idle level opens each period, falling when pol is clear; the line then returns to idle level
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			txOut <= 1'b1;
			txOe_n <= 1'b1;
		end
		else
		begin
			txOe_n <= !en || rx;
			if (txState_ff != TX_IDLE && segCnt_ff < `SNT_PULSE_TICKS)
				txOut <= pol;
			else
				txOut <= !pol;
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	assign fallEdge = rx && run && rxPrev_ff && !rxIn;
	assign inWindow = measCnt_ff >= con3_ff && measCnt_ff <= con2_ff;
	assign rxNibEdge = fallEdge && rxSynced_ff && !rxPause_ff;
	assign rxTicks = ticksOf(measCnt_ff, syncCap_ff);
	assign rxBad = rxTicks < `SNT_NIB_MIN || rxTicks > `SNT_NIB_MAX;
	assign rxVal = 4'(rxTicks - `SNT_NIB_MIN);
	assign rxStore = rxNibEdge && !rxBad;
	assign rxDone = rxStore && rxNib_ff == `SNT_NIB_CRC;
	assign rxCrcBad = rxDone && hw_checksum_enable && rxVal != crcNib(rxCrc_ff, 4'h0);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rxPrev_ff <= 1'b1;
			measCnt_ff <= 16'h0000;
		end
		else
		begin
			rxPrev_ff <= rxIn;
			// the edge cycle counts too, so the capture equals the interval length
			if (fallEdge)
				measCnt_ff <= {15'h0000, psEn};
			else if (rx && psEn && measCnt_ff != 16'hffff)
				measCnt_ff <= measCnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rxSynced_ff <= 1'b0;
			rxPause_ff <= 1'b0;
			rxNib_ff <= 3'h0;
			rxCrc_ff <= `SNT_CRC_SEED;
			syncCap_ff <= 16'h0000;
		end
		else if (!rx || !en)
		begin
			rxSynced_ff <= 1'b0;
			rxPause_ff <= 1'b0;
			rxNib_ff <= 3'h0;
		end
		else if (fallEdge)
		begin
			if (rxPause_ff)
				rxPause_ff <= 1'b0;
			else if (!rxSynced_ff)
			begin
				if (inWindow)
				begin
					rxSynced_ff <= 1'b1;
					syncCap_ff <= measCnt_ff;
					rxNib_ff <= 3'h0;
					rxCrc_ff <= `SNT_CRC_SEED;
				end
			end
			else if (rxBad)
				rxSynced_ff <= 1'b0;
			else if (rxNib_ff == `SNT_NIB_CRC)
			begin
				rxSynced_ff <= 1'b0;
				rxPause_ff <= pause_present;
				rxNib_ff <= 3'h0;
			end
			else
			begin
				if (rxNib_ff != 3'h0)
					rxCrc_ff <= crcNib(rxCrc_ff, rxVal);
				rxNib_ff <= (rxNib_ff == data_nibble_count) ? `SNT_NIB_CRC : rxNib_ff + 3'h1;
			end
		end
	end

	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			checksum_error_flag_ff <= 1'b0;
			framing_error_flag_ff <= 1'b0;
		end
		else
		begin
			if (rxCrcBad)
				checksum_error_flag_ff <= 1'b1;
			else if (wrStat && !regWrData[`SNT_ST_CHECKSUM_ERROR_FLAG])
				checksum_error_flag_ff <= 1'b0;
			if (rxNibEdge && rxBad)
				framing_error_flag_ff <= 1'b1;
			else if (wrStat && !regWrData[`SNT_ST_FRAMING_ERROR_FLAG])
				framing_error_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			idle_ff <= 1'b0;
			frameDone <= 1'b0;
			spcEnable <= 1'b0;
		end
		else
		begin
			idle_ff <= rx && en && rxIn && measCnt_ff >= con2_ff;
			frameDone <= txFrameEnd || rxDone;
			spcEnable <= rx && en && con1_ff[`SNT_SPC];
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_comb
	begin
		statLow[`SNT_ST_PAUSE] = rx ? rxPause_ff : txState_ff == TX_PAUSE;
		statLow[6:4] = rx ? rxNib_ff : (txState_ff == TX_NIB ? txNib_ff : 3'h0);
		statLow[`SNT_ST_CHECKSUM_ERROR_FLAG] = checksum_error_flag_ff;
		statLow[`SNT_ST_FRAMING_ERROR_FLAG] = framing_error_flag_ff;
		statLow[1] = idle_ff;
		statLow[`SNT_ST_SYNCTX] = rx ? rxSynced_ff : (transmit_trigger_mode ? syncTx_ff : en);
	end

	// read data stand for the one cycle after the strobe only
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			regRdData <= 16'h0000;
		else if (!regRd)
			regRdData <= 16'h0000;
		else
			unique case (regAddr)
				`SNT_REG_CON1: regRdData <= con1_ff;
				`SNT_REG_CON2: regRdData <= con2_ff;
				`SNT_REG_CON3: regRdData <= con3_ff;
				`SNT_REG_STAT: regRdData <= {8'h00, statLow};
				`SNT_REG_DATL: regRdData <= rx ? datL_ff : {datL_ff[15:4], txCrc};
				`SNT_REG_DATH: regRdData <= datH_ff;
				`SNT_REG_SYNC: regRdData <= syncCap_ff;
				default: regRdData <= 16'h0000;
			endcase
	end
endmodule : snt_transceiver

/* File: verification/snt_transceiver_assertions.sv */
`timescale 1ns/1ns
`include "snt_regs.svh"

module snt_transceiver_assertions (
	input wire logic core_clk,
	input wire logic rstn,
	input wire snt_pkg::snt_addr_t regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regRdData,
	input wire logic idleMode,
	input wire logic rxIn,
	input wire logic txOut,
	input wire logic txOe_n,
	input wire logic frameDone,
	input wire logic spcEnable
);
	import snt_pkg::*;
	logic [15:0] ctlOne_ff;
	logic [15:0] ctlTwo_ff;
	logic [3:0] quiet_ff;
	logic [15:0] gap_ff;
	logic prevTx_ff;
	logic seen_ff;
	logic txFell;
	logic gapOn;
	int tickClk;
	int gapLen;

	// ----
	// shadow state
	// ----
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctlOne_ff <= 16'h0000;
			ctlTwo_ff <= 16'h0000;
		end
		else if (regWr && regAddr == `SNT_REG_CON1)
			ctlOne_ff <= regWrData & `SNT_CON1_WMASK;
		else if (regWr && regAddr == `SNT_REG_CON2)
			ctlTwo_ff <= regWrData;
	end

	// outputs lag a control write by a few cycles, so level checks wait for it to settle
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			quiet_ff <= 4'h0;
		else if (regWr && regAddr == `SNT_REG_CON1)
			quiet_ff <= 4'h0;
		else if (quiet_ff != 4'hf)
			quiet_ff <= quiet_ff + 4'h1;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prevTx_ff <= 1'b1;
			gap_ff <= 16'h0000;
			seen_ff <= 1'b0;
		end
		else
		begin
			prevTx_ff <= txOut;
			gap_ff <= txFell ? 16'h0000 : gap_ff + {15'h0000, gap_ff != 16'hffff};
			seen_ff <= gapOn && (seen_ff || txFell);
		end
	end

	assign txFell = prevTx_ff && !txOut;
	// an idle halt or a control write breaks the spacing, so the watch restarts after it
	assign gapOn = ctlOne_ff[15] && !ctlOne_ff[11] && !ctlOne_ff[9] && !idleMode
		&& quiet_ff == 4'hf;
	assign tickClk = (int'(ctlTwo_ff) + 1) * (ctlOne_ff[`SNT_PS] ? 4 : 1);
	assign gapLen = int'(gap_ff) + 1;

	// ----
	// properties
	// ----
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence rdCtrl;
		regRd && regAddr == `SNT_REG_CON1;
	endsequence
	sequence ctlSettled;
		quiet_ff >= 4'h4;
	endsequence

	a_read_quiet: assert property (!regRd |=> regRdData == 16'h0000)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (regRd && regAddr == 3'h7 |=> regRdData == 16'h0000)
		else $error("unmapped read not zero");
	a_ctrl_readback: assert property (rdCtrl |=> regRdData == $past(ctlOne_ff))
		else $error("control word read back wrong");
	a_no_drive_rx: assert property ((!ctlOne_ff[15] || ctlOne_ff[11])[*4] |-> txOe_n)
		else $error("line driven while disabled or receiving");
	a_idle_level: assert property (ctlSettled |-> ctlOne_ff[15] || txOut == !ctlOne_ff[9])
		else $error("idle level wrong");
	a_spc_gate: assert property (ctlSettled |-> spcEnable
		== (ctlOne_ff[15] && ctlOne_ff[11] && ctlOne_ff[6]))
		else $error("short pwm enable wrong");
	a_done_single: assert property (frameDone |=> !frameDone)
		else $error("frame done longer than one cycle");
	a_done_enabled: assert property (frameDone |-> $past(ctlOne_ff[15]))
		else $error("frame done while disabled");
	a_gap_floor: assert property (seen_ff && gapOn && txFell |-> gapLen >= 12 * tickClk)
		else $error("edge interval below twelve ticks");
	a_gap_ceiling: assert property (seen_ff && gapOn && txFell && !ctlOne_ff[7]
		&& !ctlOne_ff[10] |-> gapLen <= 56 * tickClk)
		else $error("edge interval above sync length");
endmodule : snt_transceiver_assertions

bind snt_transceiver snt_transceiver_assertions snt_transceiver_assertions_i (
	.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .idleMode(idleMode),
	.rxIn(rxIn), .txOut(txOut), .txOe_n(txOe_n), .frameDone(frameDone),
	.spcEnable(spcEnable)
);

/* File: verification/snt_line_model.sv */
`timescale 1ns/1ns

module snt_line_model (
	input wire logic core_clk,
	input wire logic lineIn,
	output logic lineOut
);
	int gaps[$];
	int cnt = 0;
	logic prevIn = 1'b1;

	// ----
	// far-end receiver: falling-edge intervals in core clocks
	// ----
	always @(posedge core_clk)
	begin
		prevIn <= lineIn;
		cnt <= cnt + 1;
		if (prevIn && !lineIn)
		begin
			gaps.push_back(cnt);
			cnt <= 1;
		end
	end

	// ----
	// far-end transmitter
	// ----
	// the line is pulled up, so between frames it rests high
	initial lineOut = 1'b1;

	task send(input int ticks, input int tc);
		@(posedge core_clk);
		lineOut <= 1'b0;
		repeat (5 * tc) @(posedge core_clk);
		lineOut <= 1'b1;
		repeat ((ticks - 5) * tc - 1) @(posedge core_clk);
	endtask : send
endmodule : snt_line_model

/* File: verification/snt_transceiver_bench.sv */
`timescale 1ns/1ns
`include "snt_regs.svh"

module snt_transceiver_bench;
	import snt_pkg::*;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	snt_addr_t regAddr = 3'h0;
	logic [15:0] regWrData = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic idleMode = 1'b0;
	logic [15:0] regRdData;
	logic txOut, txOe_n, frameDone, spcEnable, farOut;
	wire lineLvl;
	int fails = 0;
	int checked = 0;

	// released driver reads as the pulled-up level
	assign lineLvl = (txOe_n ? 1'b1 : txOut) & farOut;
	always #2 core_clk = ~core_clk;

	snt_transceiver snt_transceiver_i (
		.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .idleMode(idleMode),
		.rxIn(lineLvl), .txOut(txOut), .txOe_n(txOe_n), .frameDone(frameDone),
		.spcEnable(spcEnable)
	);
	snt_line_model snt_line_model_i (.core_clk(core_clk), .lineIn(lineLvl), .lineOut(farOut));

	// ----
	// helpers
	// ----
	task complete_run();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask : wr

	task rd(input logic [2:0] a, output logic [15:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		@(negedge core_clk);
		v = regRdData;
	endtask : rd

	task chk_rd(input logic [2:0] a, input logic [15:0] exp);
		logic [15:0] v;
		rd(a, v);
		chk(v, exp);
	endtask : chk_rd

	task wait_done(input int n);
		int k;
		k = 0;
		while (n > 0 && k < 40000)
		begin
			@(negedge core_clk);
			k++;
			if (frameDone === 1'b1)
				n--;
		end
		if (n > 0)
		begin
			chk(32'h0, 32'h1);
			complete_run();
		end
	endtask : wait_done

	task wait_stat(input logic [15:0] m, input logic [15:0] val);
		logic [15:0] v;
		int k;
		v = 16'h0000;
		k = 0;
		while ((v & m) !== val && k < 4000)
		begin
			rd(`SNT_REG_STAT, v);
			k++;
		end
		chk(v & m, val);
		if ((v & m) !== val)
			complete_run();
	endtask : wait_stat

	task chk_gaps(input int e[$]);
		for (int i = 0; i < e.size(); i++)
			chk(snt_line_model_i.gaps[i + 1], e[i]);
	endtask : chk_gaps

	// seed 5, shift register over the data nibbles, then one zero nibble
	function automatic logic [3:0] crc4(input logic [23:0] nibble_position_status, input int n);
		logic [3:0] c;
		c = 4'h5;
		for (int i = n; i >= 0; i--)
			for (int b = 3; b >= 0; b--)
				c = {c[2:0], (i > 0) ? nibble_position_status[4 * (i - 1) + b] : 1'b0} ^ (c[3] ? 4'hd : 4'h0);
		return c;
	endfunction : crc4

	// ----
	// scenarios
	// ----
	task t_regs();
		chk_rd(`SNT_REG_CON1, 16'h0000);
		chk_rd(`SNT_REG_STAT, 16'h0000);
		wr(`SNT_REG_CON1, 16'hffff);
		chk_rd(`SNT_REG_CON1, `SNT_CON1_WMASK);
		wr(3'h7, 16'hffff);
		chk_rd(3'h7, 16'h0000);
		wr(`SNT_REG_CON1, 16'h0200);
		repeat (4) @(posedge core_clk);
		chk({txOe_n, txOut}, 2'b10);
	endtask : t_regs

	task t_tx_async();
		logic [3:0] c;
		int tc;
		int e[$];
		c = crc4(24'h0000a5, 2);
		for (int k = 0; k < 2; k++)
		begin
			tc = k ? 8 : 4;
			wr(`SNT_REG_CON1, 16'h0000);
			wr(`SNT_REG_CON2, k ? 16'h0001 : 16'h0003);
			wr(`SNT_REG_DATH, 16'h3a50);
			wr(`SNT_REG_DATL, 16'h0000);
			wr(`SNT_REG_CON1, k ? 16'h8112 : 16'h8102);
			chk_rd(`SNT_REG_DATL, {12'h000, c});
			wait_done(1);
			snt_line_model_i.gaps.delete();
			wait_done(2);
			e = '{56 * tc, 15 * tc, 22 * tc, 17 * tc, (12 + c) * tc};
			chk_gaps(e);
		end
		wr(`SNT_REG_CON1, 16'ha112);
		idleMode <= 1'b1;
		repeat (4) @(posedge core_clk);
		snt_line_model_i.gaps.delete();
		repeat (400) @(posedge core_clk);
		chk(snt_line_model_i.gaps.size(), 0);
		idleMode <= 1'b0;
		wait_done(1);
		wr(`SNT_REG_CON1, 16'h0000);
	endtask : t_tx_async

	task t_tx_sync();
		logic [15:0] v;
		logic [3:0] c;
		int e[$];
		c = crc4(24'h00000f, 1);
		wr(`SNT_REG_CON2, 16'h0003);
		wr(`SNT_REG_DATH, 16'h0f00);
		wr(`SNT_REG_DATL, 16'h0000);
		wr(`SNT_REG_CON1, 16'h8581);
		snt_line_model_i.gaps.delete();
		repeat (300) @(posedge core_clk);
		chk(snt_line_model_i.gaps.size(), 0);
		wr(`SNT_REG_STAT, 16'h0001);
		rd(`SNT_REG_STAT, v);
		chk(v & 16'h0001, 16'h0001);
		wait_stat(16'h0070, 16'h0070);
		wait_stat(16'h0080, 16'h0080);
		wait_done(1);
		repeat (4) @(posedge core_clk);
		rd(`SNT_REG_STAT, v);
		chk(v & 16'h00f1, 16'h0000);
		e = '{224, 48, 108, (12 + c) * 4};
		chk_gaps(e);
		wr(`SNT_REG_CON1, 16'h0000);
	endtask : t_tx_sync

	task t_tx_pause();
		logic [3:0] c;
		int sum;
		c = crc4(24'h000000, 1);
		wr(`SNT_REG_CON2, 16'h0003);
		wr(`SNT_REG_DATH, 16'h0000);
		for (int k = 0; k < 3; k++)
		begin
			wr(`SNT_REG_CON3, k == 0 ? 16'h035c : (k == 1 ? 16'h0bb8 : 16'h0064));
			wr(`SNT_REG_CON1, 16'h8181);
			wait_done(1);
			snt_line_model_i.gaps.delete();
			wait_done(2);
			sum = 0;
			for (int i = 1; i < 6; i++)
				sum += snt_line_model_i.gaps[i];
			chk(sum, 4 * (k == 0 ? 860 : (k == 1 ? 2047 : 104 + c)));
			wr(`SNT_REG_CON1, 16'h0000);
		end
	endtask : t_tx_pause

	task rx_frame(input logic [3:0] st, d1, d2, cr, input int bad);
		snt_line_model_i.send(56, 4);
		snt_line_model_i.send(12 + st, 4);
		snt_line_model_i.send(12 + d1 + bad, 4);
		snt_line_model_i.send(12 + d2, 4);
		snt_line_model_i.send(12 + cr, 4);
		snt_line_model_i.send(12, 4);
	endtask : rx_frame

	task t_rx();
		logic [15:0] v;
		logic [3:0] c;
		c = crc4(24'h0000c3, 2);
		wr(`SNT_REG_CON2, 16'h010e);
		wr(`SNT_REG_CON3, 16'h00b4);
		wr(`SNT_REG_CON1, 16'h8942);
		repeat (4) @(posedge core_clk);
		chk({txOe_n, spcEnable}, 2'b11);
		fork
			rx_frame(4'h6, 4'hc, 4'h3, c, 0);
			wait_done(1);
		join
		chk_rd(`SNT_REG_DATH, 16'h6c30);
		chk_rd(`SNT_REG_SYNC, 16'h00e0);
		rd(`SNT_REG_STAT, v);
		chk(v & 16'h000c, 16'h0000);
		rx_frame(4'h6, 4'hc, 4'h3, c ^ 4'h1, 0);
		wait_stat(16'h0008, 16'h0008);
		wr(`SNT_REG_STAT, 16'h0000);
		rd(`SNT_REG_STAT, v);
		chk(v & 16'h0008, 16'h0000);
		rx_frame(4'h6, 4'hc, 4'h3, c, 20);
		wait_stat(16'h0004, 16'h0004);
		wr(`SNT_REG_CON1, 16'h0000);
	endtask : t_rx

	initial
	begin
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		t_regs();
		t_tx_async();
		t_tx_sync();
		t_tx_pause();
		t_rx();
		complete_run();
	end
endmodule : snt_transceiver_bench
